// [hdl/csifl_cmd_seq.sv]
// csifl_cmd_seq: device end of the clocked serial command and status handshake
// Notes on behaviour
// (RULE1) programmer waits before clocking in the status frame after a status command
// (RULE2) primary status byte 06H means normal completion
// (RULE3) busy primary status: programmer resends status until its timeout expires
// (RULE4) any other primary status code ends polling abnormally with that code
// (RULE5) 04H unsupported command, 05H bad parameters, 07H corrupted frame
// (RULE6) write error 1CH, erase error 1AH, margin error while writing 1BH
// (RULE7) 0FH when data verification fails, 10H when security forbids the operation
// (RULE8) 15H for non-status command while busy, bad length or missing end byte
// (RULE9) programmer waits the command gap before reset or frequency set frames
// (RULE10) after reset the programmer waits, then runs status polling
// (RULE11) programmer retries reset at most 16 times on abnormal results
// (RULE12) acknowledge to reset means both ends are synchronised
// (RULE13) timeout while polling after reset stops retries at once
// (RULE14) programmer sends frequency set then polls status for the result
// (RULE15) frequency value out of range is answered with 05H
// (RULE16) ack primary with busy secondary keeps the programmer polling
// (RULE17) frequency set carries four data bytes; status and reset carry only the code
module csifl_cmd_seq
  import csifl_pkg::*;
(
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  nrst_in,
  // serial link pins
  input  wire logic  sck_in,
  input  wire logic  sdi_in,
  output logic       sdo_out,
  // flash engine side
  input  csifl_err_t err_in,
  output csifl_freq_t freq_out,
  output logic       sync_out,
  output logic       busy_out,
  output logic [7:0] result_out
);

  // ****************************************
  // state and link
  // ****************************************
  csifl_seq_t st_r;
  csifl_seq_t st_nxt;
  logic       rx_done;
  logic [7:0] rx_byte;

  // byte shifter on the link pins
  csifl_link_shifter u_shift (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .sck_in      (sck_in),
    .sdi_in      (sdi_in),
    .sdo_out     (sdo_out),
    .tx_load_in  (st_r.ld),
    .tx_byte_in  (st_r.ld_byte),
    .rx_done_out (rx_done),
    .rx_byte_out (rx_byte)
  );

  // ****************************************
  // helpers
  // ****************************************
  // one byte of the status frame by position
  function automatic logic [7:0] st_frame_byte(input logic [2:0] idx,
                                               input logic [7:0] s1,
                                               input logic [7:0] s2);
    logic [7:0] b;
    b = CSIFL_IDLE_TX;
    case (idx)
      3'h0:    b = CSIFL_STX;
      3'h1:    b = CSIFL_ST_LEN;
      3'h2:    b = s1;
      3'h3:    b = s2;
      3'h4:    b = 8'(8'h00 - CSIFL_ST_LEN - s1 - s2);
      3'h5:    b = CSIFL_ETX;
      default: b = CSIFL_IDLE_TX;
    endcase
    return b;
  endfunction

  // status code for a flash engine error report
  function automatic logic [7:0] ev_code(input csifl_ev_t k);
    logic [7:0] c;
    c = CSIFL_ST_WR_ERR;
    case (k)
      CSIFL_EV_WRITE:   c = CSIFL_ST_WR_ERR;    // see RULE6
      CSIFL_EV_ERASE:   c = CSIFL_ST_ERS_ERR;   // see RULE6
      CSIFL_EV_MARGIN:  c = CSIFL_ST_MRG_ERR;   // see RULE6
      CSIFL_EV_VERIFY:  c = CSIFL_ST_VFY_ERR;   // see RULE7
      CSIFL_EV_PROTECT: c = CSIFL_ST_PROT_ERR;  // see RULE7
      default:          c = CSIFL_ST_WR_ERR;
    endcase
    return c;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [7:0] sum_all;
    logic       start_tx;
    logic [7:0] s1;
    sum_all    = 8'(st_r.sum + rx_byte);
    start_tx   = 1'b0;
    s1         = st_r.result;
    st_nxt     = st_r;
    st_nxt.ld  = 1'b0;
    st_nxt.sync_p     = 1'b0;
    st_nxt.freq.valid = 1'b0;

    // processing time countdown
    if (st_r.busy)
    begin
      if (st_r.busy_cnt <= 16'h0001)
        st_nxt.busy = 1'b0;
      else
        st_nxt.busy_cnt = st_r.busy_cnt - 16'h0001;
    end

    // command frame receiver, paused while a status frame goes out
    if (rx_done && !st_r.tx_act)
    begin
      case (st_r.rx)
        CSIFL_RX_IDLE:
          if (rx_byte == CSIFL_SOH)
          begin
            st_nxt.rx  = CSIFL_RX_LEN;
            st_nxt.sum = 8'h00;
          end
        CSIFL_RX_LEN:
        begin
          st_nxt.len     = rx_byte;
          st_nxt.cnt     = 8'h00;
          st_nxt.sum     = rx_byte;
          st_nxt.bad_len = (rx_byte == 8'h00) || (rx_byte > CSIFL_MAX_LEN);
          st_nxt.data    = '0;
          // a length of zero or beyond the body cannot be followed; give up the frame
          st_nxt.rx      = st_nxt.bad_len ? CSIFL_RX_IDLE : CSIFL_RX_BODY;
          if (st_nxt.bad_len)
            st_nxt.result = CSIFL_ST_NACK;  // see RULE8
        end
        CSIFL_RX_BODY:
        begin
          if (st_r.cnt == 8'h00)
            st_nxt.cmd = rx_byte;
          else
            st_nxt.data = {st_r.data[23:0], rx_byte};  // frequency_data_bytes, first is msb
          st_nxt.sum = sum_all;
          st_nxt.cnt = st_r.cnt + 8'h01;
          if (st_r.cnt == st_r.len - 8'h01)
            st_nxt.rx = CSIFL_RX_SUM;
        end
        CSIFL_RX_SUM:
        begin
          st_nxt.sum = sum_all;
          st_nxt.rx  = CSIFL_RX_ETX;
        end
        CSIFL_RX_ETX:
        begin
          st_nxt.rx = CSIFL_RX_IDLE;
          if (rx_byte != CSIFL_ETX)
            st_nxt.result = CSIFL_ST_NACK;                    // see RULE8
          else if (st_r.sum != 8'h00)
            st_nxt.result = CSIFL_ST_SUM_ERR;                 // see RULE5
          else if (st_r.cmd == CSIFL_CMD_STATUS)
          begin
            if (st_r.len != CSIFL_LEN_PLAIN)
              st_nxt.result = CSIFL_ST_PRM_ERR;               // see RULE5
            start_tx = 1'b1;
          end
          else if (st_r.busy)
            st_nxt.result = CSIFL_ST_NACK;                    // see RULE8
          else if (st_r.cmd == CSIFL_CMD_RESET)
          begin
            if (st_r.len != CSIFL_LEN_PLAIN)
              st_nxt.result = CSIFL_ST_PRM_ERR;               // see RULE5
            else
            begin
              st_nxt.result   = CSIFL_ST_ACK;                 // see RULE12
              st_nxt.sync_p   = 1'b1;
              st_nxt.busy     = 1'b1;
              st_nxt.busy_cnt = CSIFL_PROC_CYC;
            end
          end
          else if (st_r.cmd == CSIFL_CMD_FREQ)
          begin
            if (st_r.len != CSIFL_LEN_FREQ)                   // see RULE17
              st_nxt.result = CSIFL_ST_PRM_ERR;
            else if (st_r.data < CSIFL_FREQ_MIN || st_r.data > CSIFL_FREQ_MAX)
              st_nxt.result = CSIFL_ST_PRM_ERR;               // see RULE15
            else
            begin
              st_nxt.result     = CSIFL_ST_ACK;
              st_nxt.freq.valid = 1'b1;
              st_nxt.freq.value = st_r.data;
              st_nxt.busy       = 1'b1;
              st_nxt.busy_cnt   = CSIFL_PROC_CYC;
            end
          end
          else
            st_nxt.result = CSIFL_ST_CMD_ERR;                 // see RULE5
        end
        default:
          st_nxt.rx = CSIFL_RX_IDLE;
      endcase
    end

    // flash engine error overrides any code stored this cycle
    if (err_in.valid)
      st_nxt.result = ev_code(err_in.kind);

    // status frame transmitter, one byte loaded after each byte boundary
    if (start_tx)
    begin
      s1            = st_r.busy ? CSIFL_ST_BUSY : st_nxt.result;  // see RULE3
      st_nxt.tx_prim = s1;
      st_nxt.tx_sec  = CSIFL_ST_ACK;
      st_nxt.tx_act = 1'b1;
      st_nxt.tx_idx = 3'h1;
      st_nxt.ld     = 1'b1;
      st_nxt.ld_byte = CSIFL_STX;
    end
    else if (rx_done && st_r.tx_act)
    begin
      st_nxt.ld = 1'b1;
      if (st_r.tx_idx == CSIFL_ST_BYTES)
      begin
        st_nxt.tx_act  = 1'b0;
        st_nxt.ld_byte = CSIFL_IDLE_TX;
      end
      else
      begin
        st_nxt.ld_byte = st_frame_byte(st_r.tx_idx, st_r.tx_prim, st_r.tx_sec);
        st_nxt.tx_idx  = st_r.tx_idx + 3'h1;
      end
    end
  end

  // registers
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      st_r        <= '0;
      st_r.rx     <= CSIFL_RX_IDLE;
      st_r.result <= CSIFL_ST_ACK;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign freq_out   = st_r.freq;
  assign sync_out   = st_r.sync_p;
  assign busy_out   = st_r.busy;
  assign result_out = st_r.result;

endmodule

// [hdl/csifl_link_shifter.sv]
// csifl_link_shifter: samples the serial link clock and moves bytes in and out, msb first
module csifl_link_shifter
  import csifl_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // serial link pins
  input  wire logic       sck_in,
  input  wire logic       sdi_in,
  output logic            sdo_out,
  // byte side
  input  wire logic       tx_load_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            rx_done_out,
  output logic [7:0]      rx_byte_out
);

  // ****************************************
  // state
  // ****************************************
  csifl_sh_t sh_r;
  csifl_sh_t sh_nxt;
  logic      rise;
  logic      fall;

  // edges are found on the second and third stages only
  assign rise = sh_r.sck_s2 & ~sh_r.sck_s3;
  assign fall = ~sh_r.sck_s2 & sh_r.sck_s3;

  // next state: sample on rising edge, shift out on falling edge
  always_comb
  begin
    sh_nxt        = sh_r;
    sh_nxt.sck_s1 = sck_in;
    sh_nxt.sck_s2 = sh_r.sck_s1;
    sh_nxt.sck_s3 = sh_r.sck_s2;
    sh_nxt.sdi_s1 = sdi_in;
    sh_nxt.sdi_s2 = sh_r.sdi_s1;
    sh_nxt.done   = 1'b0;
    if (rise)
    begin
      sh_nxt.rx_sh   = {sh_r.rx_sh[6:0], sh_r.sdi_s2};
      sh_nxt.bit_cnt = sh_r.bit_cnt + 3'h1;
      if (sh_r.bit_cnt == 3'h7)
      begin
        sh_nxt.rx_byte = {sh_r.rx_sh[6:0], sh_r.sdi_s2};
        sh_nxt.done    = 1'b1;
      end
    end
    else if (fall && sh_r.bit_cnt != 3'h0)
      sh_nxt.tx_sh = {sh_r.tx_sh[6:0], 1'b0};  // next bit out before next rise
    if (tx_load_in)
      sh_nxt.tx_sh = tx_byte_in;               // loaded just after a byte ends
  end

  // registers
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      sh_r <= '0;
    else
      sh_r <= sh_nxt;
  end

  assign sdo_out     = sh_r.tx_sh[7];
  assign rx_done_out = sh_r.done;
  assign rx_byte_out = sh_r.rx_byte;

endmodule

// [hdl/csifl_pkg.sv]
// csifl_pkg: codes, frame layout, timing and carrier types of the command and status sequencer
package csifl_pkg;

  // ****************************************
  // frame control bytes
  // ****************************************
  localparam logic [7:0] CSIFL_SOH      = 8'h01;  // command frame start
  localparam logic [7:0] CSIFL_STX      = 8'h02;  // status frame start
  localparam logic [7:0] CSIFL_ETX      = 8'h03;  // frame end
  localparam logic [7:0] CSIFL_IDLE_TX  = 8'h00;  // shifted out when no frame is pending
  localparam logic [7:0] CSIFL_MAX_LEN  = 8'h05;  // longest command body (code + 4 data)
  localparam logic [7:0] CSIFL_ST_LEN   = 8'h02;  // status body: primary + secondary
  localparam logic [2:0] CSIFL_ST_BYTES = 3'h6;   // STX LEN ST ST SUM ETX

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CSIFL_CMD_STATUS = 8'h70;
  localparam logic [7:0] CSIFL_CMD_RESET  = 8'h00;
  localparam logic [7:0] CSIFL_CMD_FREQ   = 8'h90;
  localparam logic [7:0] CSIFL_LEN_PLAIN  = 8'h01;  // status and reset: code only
  localparam logic [7:0] CSIFL_LEN_FREQ   = 8'h05;  // code + frequency_data_bytes

  // ****************************************
  // status codes
  // ****************************************
  localparam logic [7:0] CSIFL_ST_CMD_ERR  = 8'h04;
  localparam logic [7:0] CSIFL_ST_PRM_ERR  = 8'h05;
  localparam logic [7:0] CSIFL_ST_ACK      = 8'h06;
  localparam logic [7:0] CSIFL_ST_SUM_ERR  = 8'h07;
  localparam logic [7:0] CSIFL_ST_VFY_ERR  = 8'h0F;
  localparam logic [7:0] CSIFL_ST_PROT_ERR = 8'h10;
  localparam logic [7:0] CSIFL_ST_NACK     = 8'h15;
  localparam logic [7:0] CSIFL_ST_ERS_ERR  = 8'h1A;
  localparam logic [7:0] CSIFL_ST_MRG_ERR  = 8'h1B;
  localparam logic [7:0] CSIFL_ST_WR_ERR   = 8'h1C;
  localparam logic [7:0] CSIFL_ST_BUSY     = 8'hFF;

  // ****************************************
  // frequency range and processing time
  // ****************************************
  localparam logic [31:0] CSIFL_FREQ_MIN  = 32'h0000_0002;
  localparam logic [31:0] CSIFL_FREQ_MAX  = 32'h0000_0014;
  localparam int          CSIFL_CLK_MHZ   = 25;
  localparam int          CSIFL_PROC_US   = 20;   // busy time after reset or frequency set
  localparam logic [15:0] CSIFL_PROC_CYC  = 16'(CSIFL_PROC_US * CSIFL_CLK_MHZ);

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    CSIFL_EV_WRITE, CSIFL_EV_ERASE, CSIFL_EV_MARGIN, CSIFL_EV_VERIFY, CSIFL_EV_PROTECT
  } csifl_ev_t;

  typedef enum logic [2:0] {
    CSIFL_RX_IDLE, CSIFL_RX_LEN, CSIFL_RX_BODY, CSIFL_RX_SUM, CSIFL_RX_ETX
  } csifl_rx_st_t;

  // flash engine error report
  typedef struct packed {
    logic      valid;
    csifl_ev_t kind;
  } csifl_err_t;

  // accepted frequency set
  typedef struct packed {
    logic        valid;
    logic [31:0] value;
  } csifl_freq_t;

  // byte shifter state
  typedef struct packed {
    logic       sck_s1;
    logic       sck_s2;
    logic       sck_s3;
    logic       sdi_s1;
    logic       sdi_s2;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [7:0] rx_byte;
    logic       done;
  } csifl_sh_t;

  // sequencer state
  typedef struct packed {
    csifl_rx_st_t rx;
    logic [7:0]   len;
    logic [7:0]   cnt;
    logic [7:0]   cmd;
    logic [31:0]  data;
    logic [7:0]   sum;
    logic         bad_len;
    logic [7:0]   result;
    logic         busy;
    logic [15:0]  busy_cnt;
    logic         tx_act;
    logic [2:0]   tx_idx;
    logic [7:0]   tx_prim;
    logic [7:0]   tx_sec;
    logic         ld;
    logic [7:0]   ld_byte;
    logic         sync_p;
    csifl_freq_t  freq;
  } csifl_seq_t;

endpackage

// [tb/csi_flash_command_status_seq_tb_top.sv]
// csi_flash_command_status_seq_tb_top: self-checking bench of the sequencer
module csi_flash_command_status_seq_tb_top
  import csifl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in;
  logic        nrst_in;
  logic        sck;
  logic        sdi;
  logic        sdo;
  csifl_err_t  err;
  csifl_freq_t freq;
  logic        sync;
  logic        busy;
  logic [7:0]  result;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          sync_n = 0;
  int          freq_n = 0;
  int          bcnt = 0;
  int          blen = 0;
  csifl_cmd_seq i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .sck_in(sck), .sdi_in(sdi),
    .sdo_out(sdo), .err_in(err), .freq_out(freq), .sync_out(sync), .busy_out(busy),
    .result_out(result));
  csifl_prog_model i_prog (.sck_out(sck), .sdi_out(sdi), .sdo_in(sdo));
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // pulse count, busy length and hang limit
  always @(posedge clk_in)
  begin
    cyc++;
    sync_n += (sync === 1'b1);
    freq_n += (freq.valid === 1'b1);
    if (busy === 1'b1)
      bcnt++;
    else if (bcnt != 0)
    begin
      blen = bcnt;
      bcnt = 0;
    end
    if (cyc == 60000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // poll and judge the whole status frame
  task automatic poll_chk(input logic [7:0] e);
    logic [7:0] p;
    bit         tmo;
    i_prog.poll(8, p, tmo);
    chk("timeout", 0, tmo);
    chk("frame", {16'h0, 16'h0202, e, 8'h06, 8'h00 - 8'h08 - e, 8'h03}, i_prog.fr);
    chk("result code", e, result);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_engine();
    logic [7:0] code [5] = '{8'h1C, 8'h1A, 8'h1B, 8'h0F, 8'h10};
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk_in);
      #1 err = '{1'b1, csifl_ev_t'(k)};
      @(posedge clk_in);
      #1 err.valid = 1'b0;
      poll_chk(code[k]);
    end
  endtask
  task automatic t_frames();
    logic [7:0] cmd [4] = '{8'h55, 8'h90, 8'h90, 8'h70};
    logic [7:0] len [4] = '{8'h01, 8'h01, 8'h05, 8'h00};
    logic [7:0] ecode [4] = '{8'h04, 8'h05, 8'h07, 8'h15};
    for (int k = 0; k < 4; k++)
    begin
      i_prog.send_cmd(cmd[k], len[k], 32'h5, {7'h0, k == 2});
      poll_chk(ecode[k]);
    end
  endtask
  task automatic t_reset();
    int         s0;
    logic [7:0] p;
    bit         tmo;
    int         tries;
    s0 = sync_n;
    i_prog.send_cmd(CSIFL_CMD_RESET, CSIFL_LEN_PLAIN, 32'h0, 8'h00);
    i_prog.send_cmd(CSIFL_CMD_RESET, CSIFL_LEN_PLAIN, 32'h0, 8'h00);
    poll_chk(8'h15);
    chk("sync count", 1, sync_n - s0);
    chk("busy length", CSIFL_PROC_CYC, blen);
    i_prog.reset_seq(p, tmo, tries);
    chk("reset tries", 1, tries);
    chk("reset status", 8'h06, p);
  endtask
  task automatic t_freq();
    logic [31:0] val [4] = '{32'h14, 32'h15, 32'h01, 32'h02};
    logic [7:0]  ecode [4] = '{8'h06, 8'h05, 8'h05, 8'h06};
    logic [31:0] held = 32'h0;
    int          f0;
    f0 = freq_n;
    for (int k = 0; k < 4; k++)
    begin
      i_prog.send_cmd(CSIFL_CMD_FREQ, CSIFL_LEN_FREQ, val[k], 8'h00);
      poll_chk(ecode[k]);
      held = (ecode[k] == 8'h06) ? val[k] : held;
      chk("frequency", held, freq.value);
    end
    chk("freq pulses", 2, freq_n - f0);
  endtask
  // reset refused while busy is retried; a poll limit of one runs out while busy
  task automatic t_retry();
    int         s0;
    logic [7:0] p;
    bit         tmo;
    int         tries;
    s0 = sync_n;
    i_prog.send_cmd(CSIFL_CMD_RESET, CSIFL_LEN_PLAIN, 32'h0, 8'h00);
    i_prog.reset_seq(p, tmo, tries);
    chk("retry tries", 2, tries);
    chk("retry status", CSIFL_ST_ACK, p);
    chk("retry timeout", 0, tmo);
    chk("retry sync count", 2, sync_n - s0);
    i_prog.send_cmd(CSIFL_CMD_RESET, CSIFL_LEN_PLAIN, 32'h0, 8'h00);
    i_prog.poll(1, p, tmo);
    chk("busy primary", CSIFL_ST_BUSY, p);
    chk("poll timeout", 1, tmo);
  endtask
  // main sequence
  initial
  begin
    nrst_in = 1'b0;
    err = '0;
    repeat (12) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    poll_chk(8'h06);
    t_engine();
    t_frames();
    t_reset();
    t_freq();
    t_retry();
    report_and_stop();
  end
endmodule

// [tb/csifl_cmd_seq_props.sv]
// csifl_cmd_seq_props: port checker of the command and status sequencer
module csifl_cmd_seq_props
  import csifl_pkg::*;
(
  // clock, reset and link
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        sck_in,
  input wire logic        sdi_in,
  input wire logic        sdo_out,
  // engine side
  input wire csifl_err_t  err_in,
  input wire csifl_freq_t freq_out,
  input wire logic        sync_out,
  input wire logic        busy_out,
  input wire logic [7:0]  result_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  localparam logic [7:0] EV_CODE [5] = '{8'h1C, 8'h1A, 8'h1B, 8'h0F, 8'h10};
  logic [9:0] blen_r;
  logic [3:0] quiet_r;
  logic       sck_d_r;
  // ****************************************
  // busy length and cycles since a link clock edge
  // ****************************************
  always_ff @(posedge clk_in)
  begin
    sck_d_r <= sck_in;
    blen_r  <= (!nrst_in || !busy_out) ? 10'h000 : blen_r + 10'h001;
    quiet_r <= (!nrst_in || sck_in != sck_d_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
  end
  sequence s_accept;
    sync_out || freq_out.valid;
  endsequence
  a_accept_busy: assert property (s_accept |-> ##[0:2] busy_out)
    else $error("busy missing after accepted command");
  a_freq_range: assert property (freq_out.valid |->
    freq_out.value >= CSIFL_FREQ_MIN && freq_out.value <= CSIFL_FREQ_MAX)
    else $error("frequency outside range accepted");
  a_busy_len: assert property ($fell(busy_out) |-> blen_r == CSIFL_PROC_CYC[9:0])
    else $error("busy period of wrong length");
  a_sync_ack: assert property (sync_out |-> ##[0:2] result_out == 8'h06)
    else $error("reset not acknowledged");
  a_err_code: assert property (err_in.valid && err_in.kind <= CSIFL_EV_PROTECT |=>
    result_out == EV_CODE[$past(err_in.kind)])
    else $error("engine error code wrong");
  a_pulse_single: assert property (s_accept |=> !sync_out && !freq_out.valid)
    else $error("accept pulse too long");
  a_busy_cause: assert property ($rose(busy_out) |->
    sync_out || freq_out.valid || $past(sync_out) || $past(freq_out.valid))
    else $error("busy without accepted command");
  a_busy_refuse: assert property ($past(busy_out, 3) && busy_out |-> !sync_out && !freq_out.valid)
    else $error("command accepted while busy");
  a_sdo_clocked: assert property ($changed(sdo_out) |-> quiet_r < 4'h9)
    else $error("serial output moved without link clock");
endmodule

bind csifl_cmd_seq csifl_cmd_seq_props i_props (.clk_in(clk_in), .nrst_in(nrst_in),
  .sck_in(sck_in), .sdi_in(sdi_in), .sdo_out(sdo_out), .err_in(err_in), .freq_out(freq_out),
  .sync_out(sync_out), .busy_out(busy_out), .result_out(result_out));

// [tb/csifl_prog_model.sv]
// csifl_prog_model: programmer at the far end of the serial link
module csifl_prog_model
  import csifl_pkg::*;
#(
  parameter int POLL_NS = 2000, // status_frame_wait
  parameter int GAP_NS = 2000,  // command_gap_wait
  parameter int RST_NS = 400    // reset_status_wait
)
(
  // serial link pins
  output logic      sck_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] fr;  // last status frame, first byte highest
  initial
  begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end
  // one byte msb first; link clock rests low between bytes
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sdi_out = tx[i];
      #160 sck_out = 1'b1;
      rx[i] = sdo_in;
      #160 sck_out = 1'b0;
    end
    sdi_out = ~tx[0];  // a released line must not keep its value
    #400;
  endtask
  // command frame with checksum, adj spoils the sum
  task automatic send_cmd(input logic [7:0] cmd, input logic [7:0] len,
                          input logic [31:0] d, input logic [7:0] adj);
    logic [7:0] rx;
    if (len != CSIFL_LEN_FREQ)
      d = 32'h0;
    if (cmd != CSIFL_CMD_STATUS)
      #GAP_NS;
    xfer(8'h01, rx);
    xfer(len, rx);
    xfer(cmd, rx);
    if (len == CSIFL_LEN_FREQ)
      for (int i = 3; i >= 0; i--)
        xfer(d[8*i +: 8], rx);
    xfer(8'h00 - len - cmd - d[31:24] - d[23:16] - d[15:8] - d[7:0] + adj, rx);
    xfer(8'h03, rx);
  endtask
  // status polling, resent while busy up to limit tries
  task automatic poll(input int limit, output logic [7:0] p, output bit tmo);
    logic [7:0] rx;
    tmo = 1'b0;
    for (int n = 0; n < limit; n++)
    begin
      send_cmd(CSIFL_CMD_STATUS, CSIFL_LEN_PLAIN, 32'h0, 8'h00);
      #POLL_NS;
      fr = 64'h0;
      for (int i = 0; i < 6; i++)
      begin
        xfer(8'h00, rx);
        fr = {fr[55:0], rx};
      end
      p = fr[31:24];
      if (p != 8'hFF && !(p == 8'h06 && fr[23:16] == 8'hFF))
        return;
    end
    tmo = 1'b1;
  endtask
  // reset sequence with bounded retries
  task automatic reset_seq(output logic [7:0] p, output bit tmo, output int tries);
    for (tries = 1; tries <= 16; tries++)
    begin
      send_cmd(CSIFL_CMD_RESET, CSIFL_LEN_PLAIN, 32'h0, 8'h00);
      #RST_NS;
      poll(8, p, tmo);
      if (tmo || p == 8'h06)
        return;
    end
  endtask
endmodule
